// ===== src/rtc_pkg.sv
/*
  Shared constants and types for the serial clock/calendar block: byte map, field positions,
  reset values, bus address and oscillator figures.
  Assumes a single system clock domain; all pins are sampled by the block itself.
*/
package rtc_pkg;

  // Bus address byte with the direction bit cleared.
  localparam logic [7:0] SLAVE_WORD = 8'hd0;

  // Byte locations of the clock/calendar registers.
  localparam logic [5:0] SECONDS_COUNT = 6'h00;
  localparam logic [5:0] MINUTES_COUNT = 6'h01;
  localparam logic [5:0] CENTURY_HOURS_COUNT = 6'h02;
  localparam logic [5:0] WEEKDAY_COUNT = 6'h03;
  localparam logic [5:0] DAY_OF_MONTH_COUNT = 6'h04;
  localparam logic [5:0] MONTH_COUNT = 6'h05;
  localparam logic [5:0] YEAR_COUNT = 6'h06;
  localparam logic [5:0] OUTPUT_CALIBRATION_CONTROL = 6'h07;
  localparam int TIME_REG_COUNT = 8;
  localparam int MEM_DEPTH = 64;

  // Field positions.
  localparam int HALT_FLAG_BIT = 7;
  localparam int CENTURY_TOGGLE_ENABLE_BIT = 7;
  localparam int CENTURY_FLAG_BIT = 6;
  localparam int OUT_LEVEL_BIT = 7;
  localparam int FREQ_TEST_ENABLE_BIT = 6;
  localparam int CAL_SIGN_BIT = 5;

  // Counter limits in BCD.
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WEEKDAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;

  // Reset values of the clock bytes.
  localparam logic [7:0] SECONDS_RESET = 8'h00;
  localparam logic [7:0] MINUTES_RESET = 8'h00;
  localparam logic [7:0] HOURS_RESET = 8'h00;
  localparam logic [7:0] WEEKDAY_RESET = 8'h01;
  localparam logic [7:0] DATE_RESET = 8'h01;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [7:0] YEAR_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Oscillator figures: edges per second and the divider tap for the test frequency.
  localparam int OSC_EDGES_PER_SEC = 32768;
  localparam int FREQ_TEST_TAP = 5;

  // One byte write from the serial port.
  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
  } byte_wr_t;

endpackage

// ===== src/rtc_ram.sv
/*
  Byte memory behind the serial port: one write port, one registered read port.
  Assumes the caller masks writes to locations it keeps in its own registers.
*/
module rtc_ram
  import rtc_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Write port.
  input wire byte_wr_t wr_i,
  // Read port.
  input wire logic [5:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [MEM_DEPTH];

  // Stores a written byte.
  always_ff @(posedge clk_i) begin
    if (wr_i.en) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  // Reads out through a register.
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_q[raddr_i];
  end

endmodule

// ===== src/rtc_core.sv
/*
  Serial clock/calendar: two-wire bus slave with an auto-incrementing byte pointer, BCD time
  counters in the lowest bytes, general RAM above them, and a programmable output pin.
  Assumes scl_i, sda_i, osc_i and power_fail_i are asynchronous pins; the data pin is open-drain
  and resolved outside from sda_o and sda_oe_n_o.
*/
module rtc_core
  import rtc_pkg::*;
#(
  parameter int OSC_EDGES = OSC_EDGES_PER_SEC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Two-wire bus.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Crystal oscillator and supply monitor.
  input wire logic osc_i,
  input wire logic power_fail_i,
  // Programmable output.
  output logic test_or_level_pin_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
  } bus_state_t;

  bus_state_t state_q;
  logic [2:0] scl_sync_q, sda_sync_q, osc_sync_q;
  logic [1:0] pf_sync_q;
  logic scl_rise, scl_fall, start_seen, stop_seen, pf_q, osc_rise, tick_q, byte_end;
  logic [3:0] bitcnt_q;
  logic [7:0] rx_q, tx_q, rd_byte, ram_rdata;
  logic rw_q, nack_q, oe_n_q, sda_out_q, pin_q;
  logic [5:0] ptr_q;
  logic [15:0] osc_cnt_q;
  logic [7:0] treg_q [TIME_REG_COUNT];
  logic [7:0] treg_d [TIME_REG_COUNT];
  logic [8:0] sec_s, min_s, hr_s, wd_s, dt_s, mo_s, yr_s;
  logic yr_wrap, halt;
  byte_wr_t wr, ram_wr;

  // Steps a BCD value by one; returns the carry above the value and wraps to lo past hi.
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    if (v >= hi) begin
      bcd_step = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of a month in BCD, with leap years every fourth year.
  function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    unique case (mo[4:0])
      5'h02: month_days = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // Brings the pins into the clock domain; first stages feed only the next stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      osc_sync_q <= 3'h0;
      pf_sync_q <= 2'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      osc_sync_q <= {osc_sync_q[1:0], osc_i};
      pf_sync_q <= {pf_sync_q[0], power_fail_i};
    end
  end

  // Bus events seen on the synchronised lines.
  assign pf_q = pf_sync_q[1];
  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  assign start_seen = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[2] && !sda_sync_q[1];
  assign stop_seen = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[2] && sda_sync_q[1];
  assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
  assign byte_end = scl_fall && bitcnt_q == 4'h8;

  // Byte shown to a reader: clock registers below eight, memory above.
  assign rd_byte = (ptr_q < 6'(TIME_REG_COUNT)) ? treg_q[ptr_q[2:0]] : ram_rdata;

  // Write of a received data byte; blocked while power is failing.
  assign wr.en = (state_q == S_WDATA) && byte_end && !pf_q;
  assign wr.addr = ptr_q;
  assign wr.data = rx_q;
  assign ram_wr.en = wr.en && (ptr_q >= 6'(TIME_REG_COUNT));
  assign ram_wr.addr = ptr_q;
  assign ram_wr.data = rx_q;

  // Bus protocol engine; power fail holds it idle and release lets it listen again.
  always_ff @(posedge clk_i) begin
    if (rst_i || pf_q) begin
      state_q <= S_IDLE;
      bitcnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (start_seen) begin
      state_q <= S_ADDR;
      bitcnt_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else if (stop_seen) begin
      state_q <= S_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          oe_n_q <= 1'b1;
        end
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_sync_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_end) begin
            bitcnt_q <= 4'h0;
            if (state_q != S_ADDR) begin
              oe_n_q <= 1'b0;
              state_q <= (state_q == S_PTR) ? S_PTR_ACK : S_WDATA_ACK;
            end else if (rx_q[7:1] == SLAVE_WORD[7:1]) begin
              oe_n_q <= 1'b0;
              rw_q <= rx_q[0];
              state_q <= S_ADDR_ACK;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q <= S_RDATA;
              oe_n_q <= rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
            end else begin
              state_q <= S_PTR;
              oe_n_q <= 1'b1;
            end
          end
        end
        S_PTR_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            state_q <= S_WDATA;
            oe_n_q <= 1'b1;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_end) begin
            bitcnt_q <= 4'h0;
            oe_n_q <= 1'b1;
            state_q <= S_RDATA_ACK;
          end else if (scl_fall) begin
            oe_n_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        S_RDATA_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_sync_q[1];
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= S_IDLE;
            end else begin
              state_q <= S_RDATA;
              oe_n_q <= rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  // Byte pointer: loaded by the first written byte, then stepped after every data byte.
  always_ff @(posedge clk_i) begin
    if (rst_i || pf_q) begin
      ptr_q <= 6'h00;
    end else if (state_q == S_PTR && byte_end) begin
      ptr_q <= rx_q[5:0];
    end else if (wr.en || (state_q == S_RDATA && byte_end)) begin
      ptr_q <= ptr_q + 6'h01;
    end
  end

  // Divides the oscillator down to one tick a second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (osc_rise) begin
        if (osc_cnt_q == 16'(OSC_EDGES - 1)) begin
          osc_cnt_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          osc_cnt_q <= osc_cnt_q + 16'h0001;
        end
      end
    end
  end

  assign halt = treg_q[SECONDS_COUNT[2:0]][HALT_FLAG_BIT];

  // Next time values after one second, carrying from seconds up to the century flag.
  always_comb begin
    for (int i = 0; i < TIME_REG_COUNT; i++) begin
      treg_d[i] = treg_q[i];
    end
    yr_wrap = 1'b0;
    min_s = 9'h000;
    hr_s = 9'h000;
    wd_s = 9'h000;
    dt_s = 9'h000;
    mo_s = 9'h000;
    yr_s = 9'h000;
    sec_s = bcd_step({1'b0, treg_q[0][6:0]}, SEC_MAX, BCD_ZERO);
    treg_d[0][6:0] = sec_s[6:0];
    if (sec_s[8]) begin
      min_s = bcd_step({1'b0, treg_q[1][6:0]}, MIN_MAX, BCD_ZERO);
      treg_d[1][6:0] = min_s[6:0];
    end
    if (min_s[8]) begin
      hr_s = bcd_step({2'b00, treg_q[2][5:0]}, HOUR_MAX, BCD_ZERO);
      treg_d[2][5:0] = hr_s[5:0];
    end
    if (hr_s[8]) begin
      wd_s = bcd_step({5'h00, treg_q[3][2:0]}, WEEKDAY_MAX, BCD_ONE);
      treg_d[3][2:0] = wd_s[2:0];
      dt_s = bcd_step({2'b00, treg_q[4][5:0]}, month_days(treg_q[5], treg_q[6]), BCD_ONE);
      treg_d[4][5:0] = dt_s[5:0];
    end
    if (dt_s[8]) begin
      mo_s = bcd_step({3'h0, treg_q[5][4:0]}, MONTH_MAX, BCD_ONE);
      treg_d[5][4:0] = mo_s[4:0];
    end
    if (mo_s[8]) begin
      yr_s = bcd_step(treg_q[6], YEAR_MAX, BCD_ZERO);
      treg_d[6] = yr_s[7:0];
      yr_wrap = yr_s[8];
    end
    if (yr_wrap && treg_q[2][CENTURY_TOGGLE_ENABLE_BIT]) begin
      treg_d[2][CENTURY_FLAG_BIT] = !treg_q[2][CENTURY_FLAG_BIT];
    end
  end

  // Clock registers: a bus write wins over the second tick; the halt flag freezes counting.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      treg_q[0] <= SECONDS_RESET;
      treg_q[1] <= MINUTES_RESET;
      treg_q[2] <= HOURS_RESET;
      treg_q[3] <= WEEKDAY_RESET;
      treg_q[4] <= DATE_RESET;
      treg_q[5] <= MONTH_RESET;
      treg_q[6] <= YEAR_RESET;
      treg_q[7] <= CONTROL_RESET;
    end else if (wr.en && wr.addr < 6'(TIME_REG_COUNT)) begin
      treg_q[wr.addr[2:0]] <= wr.data;
    end else if (tick_q && !halt) begin
      for (int i = 0; i < TIME_REG_COUNT; i++) begin
        treg_q[i] <= treg_d[i];
      end
    end
  end

  // Output pin: the test frequency when enabled, otherwise the programmed level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      if (treg_q[7][FREQ_TEST_ENABLE_BIT]) begin
        pin_q <= osc_cnt_q[FREQ_TEST_TAP];
      end else begin
        pin_q <= treg_q[7][OUT_LEVEL_BIT];
      end
    end
  end

  assign sda_o = sda_out_q;
  assign sda_oe_n_o = oe_n_q;
  assign test_or_level_pin_o = pin_q;

  // General memory above the clock registers.
  rtc_ram u_ram (
    .clk_i(clk_i),
    .wr_i(ram_wr),
    .raddr_i(ptr_q),
    .rdata_o(ram_rdata)
  );

  // Checks on the protocol engine and the counters.
  property p_addr_reject;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_ADDR && byte_end && !start_seen && !stop_seen && !pf_q && rx_q[7:1] != SLAVE_WORD[7:1])
      |=> (state_q == S_IDLE && oe_n_q);
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("Foreign address was acknowledged.");

  property p_ptr_step;
    @(posedge clk_i) disable iff (rst_i)
    wr.en |=> ptr_q == $past(ptr_q) + 6'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("Pointer did not step after a write.");

  property p_pf_abort;
    @(posedge clk_i) disable iff (rst_i)
    pf_q |=> (ptr_q == 6'h00 && state_q == S_IDLE && oe_n_q);
  endproperty
  a_pf_abort: assert property (p_pf_abort) else $error("Power fail did not abort the access.");

  property p_pf_nowrite;
    @(posedge clk_i) disable iff (rst_i)
    pf_q |-> (!wr.en && !ram_wr.en) ##1 (treg_q[7] == $past(treg_q[7]));
  endproperty
  a_pf_nowrite: assert property (p_pf_nowrite) else $error("Write during power fail.");

  property p_halt_freeze;
    @(posedge clk_i) disable iff (rst_i)
    (tick_q && halt && !wr.en) |=> treg_q[0] == $past(treg_q[0]) && treg_q[1] == $past(treg_q[1]);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("Counters moved while halted.");

  property p_sec_wrap;
    @(posedge clk_i) disable iff (rst_i)
    (tick_q && !halt && !wr.en && treg_q[0][6:0] == SEC_MAX[6:0])
      |=> treg_q[0][6:0] == 7'h00 && treg_q[1] != $past(treg_q[1]);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("Seconds did not wrap into minutes.");

  property p_century;
    @(posedge clk_i) disable iff (rst_i)
    (tick_q && !halt && !wr.en && yr_wrap)
      |=> treg_q[2][CENTURY_FLAG_BIT] == ($past(treg_q[2][CENTURY_FLAG_BIT]) ^ $past(treg_q[2][7]));
  endproperty
  a_century: assert property (p_century) else $error("Century flag wrong at year wrap.");

  property p_ack_held;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_ADDR_ACK || state_q == S_PTR_ACK || state_q == S_WDATA_ACK) |-> !oe_n_q;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("Acknowledge not driven low.");

  property p_stop_idle;
    @(posedge clk_i) disable iff (rst_i)
    (stop_seen && !start_seen) |=> state_q == S_IDLE ##1 oe_n_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not end the transfer.");

  c_burst_write: cover property (@(posedge clk_i) disable iff (rst_i) wr.en && wr.addr == YEAR_COUNT);
  c_read_byte: cover property (@(posedge clk_i) disable iff (rst_i) state_q == S_RDATA && byte_end);
  c_halted_tick: cover property (@(posedge clk_i) disable iff (rst_i) tick_q && halt);
  c_year_wrap: cover property (@(posedge clk_i) disable iff (rst_i) tick_q && !halt && yr_wrap);

endmodule

// ===== test/i2c_master_model.sv
/*
  Bus master model that stands on the far side of the clock/calendar serial port.
  Assumes the bench resolves the open-drain data wire with a pull-up and feeds it back on sda_i.
*/
module i2c_master_model (
  // Clock.
  input wire logic clk_i,
  // Resolved data wire.
  input wire logic sda_i,
  // Driven pins, a one means released.
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles high, and the clock stands still outside frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One bit of 64 ns: data moves while the clock is low and is read at the end of the high phase.
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge clk_i);
    sda_o <= b;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  // Start, also used as a repeated start: data falls while the clock is high.
  task automatic start();
    repeat (2) @(posedge clk_i);
    sda_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus is left idle.
  task automatic stop();
    repeat (2) @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // Sends a byte; ack is high when data was pulled low on the ninth clock.
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Receives a byte, then acknowledges to go on or leaves data high to end the read.
  task automatic recv(output logic [7:0] b, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~more, r);
  endtask
endmodule

// ===== test/serial_rtc_register_access_bench.sv
/*
  Self-checking bench for the serial clock/calendar: register, RAM, rollover and power-fail tests.
  Assumes the design ticks once per OSC_EDGES crystal rising edges, set to 4 here.
*/
module serial_rtc_register_access_bench
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_i = 1'b0;
  logic power_fail_i = 1'b0;
  logic scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe_n_o;
  logic pin;
  wire logic sda_w;
  int err_count = 0;
  int check_count = 0;
  logic ack;
  logic [7:0] v;

  // Open-drain data wire: low when either party pulls it, pulled up otherwise.
  assign sda_w = m_sda & (sda_oe_n_o | sda_o);

  // System clock of 8 ns.
  always #4 clk_i = ~clk_i;

  rtc_core #(.OSC_EDGES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .osc_i(osc_i), .power_fail_i(power_fail_i), .test_or_level_pin_o(pin));
  i2c_master_model m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Writes bytes from pointer p in one transfer.
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    m.start();
    m.send(SLAVE_WORD, ack);
    check("addr ack", {7'h00, ack}, 8'h01);
    m.send(p, ack);
    foreach (d[i]) begin
      m.send(d[i], ack);
      check("data ack", {7'h00, ack}, 8'h01);
    end
    m.stop();
  endtask

  // Reads bytes from pointer p, or from the current pointer when p[8] is set.
  task automatic rd(input logic [8:0] p, input logic [7:0] e[$]);
    m.start();
    if (!p[8]) begin
      m.send(SLAVE_WORD, ack);
      m.send(p[7:0], ack);
      m.start();
    end
    m.send(SLAVE_WORD | 8'h01, ack);
    check("read ack", {7'h00, ack}, 8'h01);
    foreach (e[i]) begin
      m.recv(v, i < e.size() - 1);
      check("read byte", v, e[i]);
    end
    m.stop();
  endtask

  // Runs the crystal for exactly one tick's worth of rising edges.
  task automatic tick();
    repeat (4) begin
      @(posedge clk_i) osc_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      osc_i <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask

  // Main test sequence.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(9'h000, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00});
    $display("test reset_map done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, '{8'h59, 8'h59, k ? 8'ha3 : 8'h63, 8'h07, 8'h31, 8'h12, 8'h99});
      tick();
      rd(9'h000, '{8'h00, 8'h00, k ? 8'hc0 : 8'h40, 8'h01, 8'h01, 8'h01, 8'h00});
    end
    $display("test rollover done");
    wr(8'h00, '{8'h85, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
    tick();
    rd(9'h000, '{8'h85, 8'h59, 8'h23});
    $display("test halt done");
    wr(8'h07, '{8'h80});
    check("pin high", {7'h00, pin}, 8'h01);
    // With four crystal edges a tick the divider never reaches its test tap, so the pin shows a low.
    wr(8'h07, '{8'hc0});
    check("pin test", {7'h00, pin}, 8'h00);
    wr(8'h07, '{8'h25});
    check("pin low", {7'h00, pin}, 8'h00);
    rd(9'h007, '{8'h25});
    $display("test control done");
    wr(8'h3e, '{8'ha5, 8'h5a, 8'h81});
    rd(9'h03e, '{8'ha5, 8'h5a, 8'h81});
    rd(9'h03f, '{8'h5a});
    $display("test wrap done");
    m.start();
    m.send(8'ha0, ack);
    check("foreign ack", {7'h00, ack}, 8'h00);
    m.send(8'h3e, ack);
    m.send(8'h00, ack);
    m.stop();
    rd(9'h03e, '{8'ha5});
    $display("test foreign done");
    m.start();
    m.send(SLAVE_WORD, ack);
    m.send(8'h3f, ack);
    power_fail_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    m.send(8'h11, ack);
    check("fail ack", {7'h00, ack}, 8'h00);
    m.stop();
    power_fail_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(9'h100, '{8'h81, 8'h59});
    rd(9'h03f, '{8'h5a});
    $display("test power_fail done");
    summarize();
  end

  // Watchdog that cuts a hang short.
  initial begin
    repeat (50000) @(posedge clk_i);
    err_count++;
    summarize();
  end
endmodule
